// [logic/ir_tx_pkg.sv]
// constants shared by the infrared transmit waveform generator
// assumes a 16-bit register port with 4-bit word addresses
package ir_tx_pkg;

  localparam int DATA_W = 16;
  localparam int CAR_W  = 8;
  localparam int ADDR_W = 4;

  // register word addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL       = 4'h0; // data_counter_ctrl
  localparam logic [ADDR_W-1:0] ADDR_DUTY       = 4'h1; // data_duty_reg
  localparam logic [ADDR_W-1:0] ADDR_PERIOD     = 4'h2; // data_period_reg
  localparam logic [ADDR_W-1:0] ADDR_CARRIER    = 4'h3; // carrier_setting_reg
  localparam logic [ADDR_W-1:0] ADDR_CAR_CTRL   = 4'h4; // carrier_ctrl_reg
  localparam logic [ADDR_W-1:0] ADDR_FLAGS      = 4'h5; // irq_flag_reg
  localparam logic [ADDR_W-1:0] ADDR_COUNT      = 4'h6; // data_count_reg

  // data_counter_ctrl fields
  localparam int BIT_CLK_EN  = 0;
  localparam int BIT_ONESHOT = 2;
  localparam int BIT_SHADOW  = 3;
  localparam int BIT_INVERT  = 4;
  localparam int BIT_RUN     = 8;
  localparam int BIT_PRESET  = 9;

  // carrier_setting_reg fields
  localparam int CAR_DUTY_LSB = 0;
  localparam int CAR_PER_LSB  = 8;

  // carrier_ctrl_reg fields
  localparam int BIT_CAR_MOD = 0;

  // irq_flag_reg fields
  localparam int BIT_DUTY_FLAG   = 0;
  localparam int BIT_PERIOD_FLAG = 1;
  localparam int BIT_RUNNING     = 8;
  localparam int BIT_DUTY_BUSY   = 9;
  localparam int BIT_PER_BUSY    = 10;

  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
  localparam logic [CAR_W-1:0]  CAR_RESET = 8'h00;

endpackage

// [logic/wave_counter.sv]
// compare counter that toggles a level on a duty match and on a period match
// assumes the caller gates run and clear from its own control state
`timescale 1ns/1ps
module wave_counter
  import ir_tx_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         clear,
  input  wire logic         run,
  input  wire logic [W-1:0] duty,
  input  wire logic [W-1:0] period,
  output logic      [W-1:0] count,
  output logic              level,
  output logic              duty_hit,
  output logic              period_hit
);

  logic [W-1:0] next_count;
  logic         next_level;

  assign period_hit = run && !clear && (count == period);
  assign duty_hit   = run && !clear && (count == duty) && !period_hit;

  always_comb
  begin
    next_count = count;
    next_level = level;
    if (clear)
    begin
      next_count = '0;   // R8
      next_level = 1'b1; // R25
    end
    else if (period_hit)
    begin
      next_count = '0;     // R9 R13
      next_level = !level; // R9 R13
    end
    else if (run)
    begin
      next_count = count + 1'b1; // R5 R10
      if (duty_hit)
        next_level = !level; // R9 R13
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count <= '0;
      level <= 1'b1;
    end
    else
    begin
      count <= next_count;
      level <= next_level;
    end
  end

  property p_wrap;
    @(posedge ref_clk) disable iff (!nrst)
    period_hit |=> (count == '0) && (level != $past(level));
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap on period match"); // R9

  property p_duty_toggle;
    @(posedge ref_clk) disable iff (!nrst)
    duty_hit |=> (level != $past(level)) && (count == $past(count) + 1'b1);
  endproperty
  a_duty_toggle: assert property (p_duty_toggle) else $error("level did not toggle on duty match"); // R13

  property p_advance;
    @(posedge ref_clk) disable iff (!nrst)
    run && !clear && !period_hit && !duty_hit |=> (count == $past(count) + 1'b1) && $stable(level);
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance by one"); // R11

endmodule // wave_counter

// [logic/shadow_reg.sv]
// one compare setting with its shadow buffer and busy flag
// assumes load is asserted on the data period match or while buffering is off
`timescale 1ns/1ps
module shadow_reg
  import ir_tx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              wr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              load,
  input  wire logic              enable,
  output logic      [DATA_W-1:0] value,
  output logic      [DATA_W-1:0] buffered,
  output logic                   busy
);

  logic [DATA_W-1:0] next_value;
  logic [DATA_W-1:0] next_buffered;
  logic              next_busy;

  always_comb
  begin
    next_value    = wr ? wdata : value;
    // a write in the load cycle keeps busy: the buffer takes the old value
    next_buffered = load ? value : buffered; // R18 R19
    next_busy     = enable && (wr || (busy && !load)); // R20
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      value    <= REG_RESET;
      buffered <= REG_RESET;
      busy     <= 1'b0;
    end
    else
    begin
      value    <= next_value;
      buffered <= next_buffered;
      busy     <= next_busy;
    end
  end

  property p_busy_set;
    @(posedge ref_clk) disable iff (!nrst)
    enable && wr |=> busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by write"); // R20

  property p_busy_clear;
    @(posedge ref_clk) disable iff (!nrst)
    busy && load && !wr |=> !busy && (buffered == $past(value));
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared on transfer"); // R20

endmodule // shadow_reg

// [logic/ir_tx_unit.sv]
// infrared remote transmit waveform generator: carrier and data counters,
// register port, shadowed data compares, one-shot and repeat modes.
// assumes a single-clock register master that never overlaps strobes.
//
// Notes on behaviour
// R1: software programs duty, then period, then requests counter reset and sets run.
// R2: for continuous sending software writes next values before each period match.
// R3: to stop, software waits for period match, clears run, then clock enable.
// R4: output pin is carrier AND data waveform.
// R5: carrier comes from an 8-bit counter compared to duty and period.
// R6: carrier frequency is clock over period plus one; high is duty plus one.
// R7: software keeps carrier period 1..255, duty 0..254, duty below period.
// R8: counter reset clears carrier counter; run starts it with the data counter.
// R9: carrier toggles on duty match; on period match toggles and wraps to zero.
// R10: data waveform comes from a readable 16-bit counter.
// R11: each data bit lasts period plus one cycles; active part duty plus one.
// R12: software keeps data period 1..65535, duty 0..65534, duty below period.
// R13: data toggles on duty match; on period match toggles and wraps to zero.
// R14: separate flags for data duty match and data period match.
// R15: repeat mode keeps counting until software clears run.
// R16: one-shot mode stops the counter itself on period match.
// R17: with buffering off, compares use the registers directly.
// R18: with buffering on, compares use shadow copies of the registers.
// R19: shadows reload on the buffered period match.
// R20: busy flags set on register write, clear when moved into the shadow.
// R21: output invert bit inverts the transmit output; the code inverts it only while counting, and the idle pin stays low.
// R22: carrier modulation enable chooses whether the carrier gates the data.
// R23: counter reset request reads one while in progress, clears when done.
// R24: software sets the clock enable before requesting a counter reset.
// R25: after a counter reset both waveforms start high.
`timescale 1ns/1ps
module ir_tx_unit
  import ir_tx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   ir_tx_out
);

  // control state
  logic              count_clock_enable;
  logic              preset_pending;
  logic              counter_run;
  logic              oneshot_select;
  logic              compare_shadow_enable;
  logic              output_invert;
  logic              carrier_mod_enable;
  logic [CAR_W-1:0]  carrier_period_value;
  logic [CAR_W-1:0]  carrier_duty_value;
  logic              duty_match_flag;
  logic              period_match_flag;

  logic              next_count_clock_enable;
  logic              next_preset_pending;
  logic              next_counter_run;
  logic              next_oneshot_select;
  logic              next_compare_shadow_enable;
  logic              next_output_invert;
  logic              next_carrier_mod_enable;
  logic [CAR_W-1:0]  next_carrier_period_value;
  logic [CAR_W-1:0]  next_carrier_duty_value;
  logic              next_duty_match_flag;
  logic              next_period_match_flag;
  logic              next_ir_tx_out;
  logic [DATA_W-1:0] next_rd_data;

  // decode and datapath
  logic              wr_ctrl;
  logic              wr_duty;
  logic              wr_period;
  logic              wr_flags;
  logic              counting;
  logic              counter_clear;
  logic              shadow_load;
  logic [DATA_W-1:0] data_duty_value;
  logic [DATA_W-1:0] data_period_value;
  logic [DATA_W-1:0] duty_buffer;
  logic [DATA_W-1:0] period_buffer;
  logic [DATA_W-1:0] duty_cmp;
  logic [DATA_W-1:0] period_cmp;
  logic              duty_shadow_busy;
  logic              period_shadow_busy;
  logic [DATA_W-1:0] data_count_value;
  logic              data_level;
  logic              data_duty_hit;
  logic              data_period_hit;
  logic [CAR_W-1:0]  carrier_count;
  logic              carrier_level;
  logic              carrier_gate;

  always_comb
  begin
    wr_ctrl   = 1'b0;
    wr_duty   = 1'b0;
    wr_period = 1'b0;
    wr_flags  = 1'b0;
    if (wr_en && addr == ADDR_CTRL)
      wr_ctrl = 1'b1;
    else if (wr_en && addr == ADDR_DUTY)
      wr_duty = 1'b1;
    else if (wr_en && addr == ADDR_PERIOD)
      wr_period = 1'b1;
    else if (wr_en && addr == ADDR_FLAGS)
      wr_flags = 1'b1;
  end

  // a reset request waits for the clock enable, so it is never lost
  assign counter_clear = preset_pending && count_clock_enable; // R8 R23
  assign counting      = counter_run && count_clock_enable && !preset_pending; // R8
  // shadows follow the registers while buffering is off
  assign shadow_load   = !compare_shadow_enable || counter_clear || data_period_hit; // R19
  assign duty_cmp      = compare_shadow_enable ? duty_buffer : data_duty_value; // R17 R18
  assign period_cmp    = compare_shadow_enable ? period_buffer : data_period_value; // R17 R18
  assign carrier_gate  = carrier_mod_enable ? carrier_level : 1'b1; // R22

  shadow_reg u_duty_shadow (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr       (wr_duty),
    .wdata    (wr_data),
    .load     (shadow_load),
    .enable   (compare_shadow_enable),
    .value    (data_duty_value),
    .buffered (duty_buffer),
    .busy     (duty_shadow_busy)
  );

  shadow_reg u_period_shadow (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .wr       (wr_period),
    .wdata    (wr_data),
    .load     (shadow_load),
    .enable   (compare_shadow_enable),
    .value    (data_period_value),
    .buffered (period_buffer),
    .busy     (period_shadow_busy)
  );

  wave_counter #(
    .W (DATA_W)
  ) u_data_counter (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .clear      (counter_clear),
    .run        (counting),
    .duty       (duty_cmp),
    .period     (period_cmp), // R11
    .count      (data_count_value),
    .level      (data_level),
    .duty_hit   (data_duty_hit),
    .period_hit (data_period_hit)
  );

  wave_counter #(
    .W (CAR_W)
  ) u_carrier_counter (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .clear      (counter_clear),
    .run        (counting),
    .duty       (carrier_duty_value),
    .period     (carrier_period_value), // R6
    .count      (carrier_count),
    .level      (carrier_level),
    .duty_hit   (),
    .period_hit ()
  );

  always_comb
  begin
    next_count_clock_enable    = count_clock_enable;
    next_oneshot_select        = oneshot_select;
    next_compare_shadow_enable = compare_shadow_enable;
    next_output_invert         = output_invert;
    next_carrier_mod_enable    = carrier_mod_enable;
    next_carrier_period_value  = carrier_period_value;
    next_carrier_duty_value    = carrier_duty_value;
    next_counter_run           = counter_run;
    next_preset_pending        = preset_pending && !count_clock_enable; // R23
    if (wr_ctrl)
    begin
      next_count_clock_enable    = wr_data[BIT_CLK_EN];
      next_oneshot_select        = wr_data[BIT_ONESHOT];
      next_compare_shadow_enable = wr_data[BIT_SHADOW];
      next_output_invert         = wr_data[BIT_INVERT];
      next_counter_run           = wr_data[BIT_RUN];
      if (wr_data[BIT_PRESET])
        next_preset_pending = 1'b1; // R23
    end
    else if (data_period_hit && oneshot_select) // R15
      next_counter_run = 1'b0; // R16
    if (wr_en && addr == ADDR_CARRIER)
    begin
      next_carrier_period_value = wr_data[CAR_PER_LSB +: CAR_W];
      next_carrier_duty_value   = wr_data[CAR_DUTY_LSB +: CAR_W];
    end
    if (wr_en && addr == ADDR_CAR_CTRL)
      next_carrier_mod_enable = wr_data[BIT_CAR_MOD];
    // a match in the clearing cycle wins over the write-one clear
    next_duty_match_flag = data_duty_hit ||
                           (duty_match_flag && !(wr_flags && wr_data[BIT_DUTY_FLAG])); // R14
    next_period_match_flag = data_period_hit ||
                             (period_match_flag && !(wr_flags && wr_data[BIT_PERIOD_FLAG])); // R14
    // idle pin stays low regardless of inversion
    next_ir_tx_out = counting ? ((data_level && carrier_gate) ^ output_invert) : 1'b0; // R4 R21
  end

  always_comb
  begin
    next_rd_data = REG_RESET;
    if (rd_en && addr == ADDR_CTRL)
    begin
      next_rd_data[BIT_CLK_EN]  = count_clock_enable;
      next_rd_data[BIT_ONESHOT] = oneshot_select;
      next_rd_data[BIT_SHADOW]  = compare_shadow_enable;
      next_rd_data[BIT_INVERT]  = output_invert;
      next_rd_data[BIT_RUN]     = counter_run;
      next_rd_data[BIT_PRESET]  = preset_pending; // R23
    end
    else if (rd_en && addr == ADDR_DUTY)
      next_rd_data = data_duty_value;
    else if (rd_en && addr == ADDR_PERIOD)
      next_rd_data = data_period_value;
    else if (rd_en && addr == ADDR_CARRIER)
    begin
      next_rd_data[CAR_PER_LSB +: CAR_W]  = carrier_period_value;
      next_rd_data[CAR_DUTY_LSB +: CAR_W] = carrier_duty_value;
    end
    else if (rd_en && addr == ADDR_CAR_CTRL)
      next_rd_data[BIT_CAR_MOD] = carrier_mod_enable;
    else if (rd_en && addr == ADDR_FLAGS)
    begin
      next_rd_data[BIT_DUTY_FLAG]   = duty_match_flag;
      next_rd_data[BIT_PERIOD_FLAG] = period_match_flag;
      next_rd_data[BIT_RUNNING]     = counting;
      next_rd_data[BIT_DUTY_BUSY]   = duty_shadow_busy; // R20
      next_rd_data[BIT_PER_BUSY]    = period_shadow_busy; // R20
    end
    else if (rd_en && addr == ADDR_COUNT)
      next_rd_data = data_count_value; // R10
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_clock_enable    <= 1'b0;
      preset_pending        <= 1'b0;
      counter_run           <= 1'b0;
      oneshot_select        <= 1'b0;
      compare_shadow_enable <= 1'b0;
      output_invert         <= 1'b0;
      carrier_mod_enable    <= 1'b0;
      carrier_period_value  <= CAR_RESET;
      carrier_duty_value    <= CAR_RESET;
      duty_match_flag       <= 1'b0;
      period_match_flag     <= 1'b0;
      ir_tx_out             <= 1'b0;
      rd_data               <= REG_RESET;
    end
    else
    begin
      count_clock_enable    <= next_count_clock_enable;
      preset_pending        <= next_preset_pending;
      counter_run           <= next_counter_run;
      oneshot_select        <= next_oneshot_select;
      compare_shadow_enable <= next_compare_shadow_enable;
      output_invert         <= next_output_invert;
      carrier_mod_enable    <= next_carrier_mod_enable;
      carrier_period_value  <= next_carrier_period_value;
      carrier_duty_value    <= next_carrier_duty_value;
      duty_match_flag       <= next_duty_match_flag;
      period_match_flag     <= next_period_match_flag;
      ir_tx_out             <= next_ir_tx_out;
      rd_data               <= next_rd_data;
    end
  end

  property p_out_and;
    @(posedge ref_clk) disable iff (!nrst)
    counting && !carrier_mod_enable |=> ir_tx_out == ($past(data_level) ^ $past(output_invert));
  endproperty
  a_out_and: assert property (p_out_and) else $error("output does not follow data level"); // R4

  property p_out_mod;
    @(posedge ref_clk) disable iff (!nrst)
    counting && carrier_mod_enable && !output_invert |=>
      ir_tx_out == ($past(data_level) && $past(carrier_level));
  endproperty
  a_out_mod: assert property (p_out_mod) else $error("output is not carrier and data"); // R22

  property p_out_inv;
    @(posedge ref_clk) disable iff (!nrst)
    counting && output_invert && !data_level |=> ir_tx_out;
  endproperty
  a_out_inv: assert property (p_out_inv) else $error("inverted output not high"); // R21

  property p_clear;
    @(posedge ref_clk) disable iff (!nrst)
    counter_clear |=> data_count_value == '0 && carrier_count == '0 && data_level && carrier_level
                      && !preset_pending;
  endproperty
  a_clear: assert property (p_clear) else $error("counter reset incomplete"); // R25

  property p_flags;
    @(posedge ref_clk) disable iff (!nrst)
    data_duty_hit |=> duty_match_flag;
  endproperty
  a_flags: assert property (p_flags) else $error("duty match flag not set"); // R14

  property p_period_flag;
    @(posedge ref_clk) disable iff (!nrst)
    data_period_hit |=> period_match_flag;
  endproperty
  a_period_flag: assert property (p_period_flag) else $error("period match flag not set"); // R14

  property p_oneshot;
    @(posedge ref_clk) disable iff (!nrst)
    data_period_hit && oneshot_select && !wr_ctrl |=> !counter_run ##1 !counter_run;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop"); // R16

  property p_repeat;
    @(posedge ref_clk) disable iff (!nrst)
    data_period_hit && !oneshot_select && !wr_ctrl |=> counter_run && data_count_value == '0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat mode stopped"); // R15

  property p_buffered;
    @(posedge ref_clk) disable iff (!nrst)
    compare_shadow_enable && data_period_hit && !wr_ctrl |=> period_cmp == $past(data_period_value);
  endproperty
  a_buffered: assert property (p_buffered) else $error("shadow not reloaded on period match"); // R19

endmodule // ir_tx_unit

// [test/ir_led_model.sv]
// behavioural load on the transmit pin: an infrared led driver
// assumes the pin is sampled on ref_clk; reports the last complete high and low run
`timescale 1ns/1ps
module ir_led_model
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        led_drive,
  output logic      [15:0] hi_len,
  output logic      [15:0] lo_len
);
  logic        prev;
  logic [15:0] run_len;

  // a real driver only sees levels, so the model measures run lengths in clock cycles
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prev    <= 1'b0;
      run_len <= 16'h0000;
      hi_len  <= 16'h0000;
      lo_len  <= 16'h0000;
    end
    else if (led_drive === prev)
      run_len <= run_len + 16'h0001;
    else
    begin
      if (prev)
        hi_len <= run_len;
      else
        lo_len <= run_len;
      prev    <= led_drive;
      run_len <= 16'h0001;
    end
  end
endmodule // ir_led_model

// [test/ir_tx_unit_tb.sv]
// self-checking bench for the infrared transmit waveform generator
// assumes the register port of the package and a 40 MHz ref_clk
`timescale 1ns/1ps
module ir_tx_unit_tb;
  import ir_tx_pkg::*;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [DATA_W-1:0] wr_data = 16'h0000;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic              ir_tx_out;
  logic [15:0]       hi_len;
  logic [15:0]       lo_len;
  int                n_mismatch = 0;
  int                n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  ir_tx_unit i_ir_tx_unit (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ir_tx_out(ir_tx_out));
  ir_led_model i_ir_led_model (.ref_clk(ref_clk), .nrst(nrst), .led_drive(ir_tx_out),
    .hi_len(hi_len), .lo_len(lo_len));

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [15:0] mask, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(exp, d & mask);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // duty then period, then counter reset with run in one write
  task automatic start(input logic [15:0] d, input logic [15:0] p, input logic [15:0] ctl);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_DUTY, d);
    wr(ADDR_PERIOD, p);
    wr(ADDR_CTRL, ctl | 16'h0301);
  endtask

  task automatic t_reset;
    chk(16'h0000, {15'h0, ir_tx_out});
    chk_reg(ADDR_CTRL, 16'hffff, 16'h0000);
    chk_reg(ADDR_COUNT, 16'hffff, 16'h0000);
    chk_reg(ADDR_FLAGS, 16'hffff, 16'h0000);
    chk_reg(4'h7, 16'hffff, 16'h0000);
    wr(ADDR_CTRL, 16'h0200);
    chk_reg(ADDR_CTRL, 16'h0200, 16'h0200);
    wr(ADDR_CTRL, 16'h0001);
    chk_reg(ADDR_CTRL, 16'h0200, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_data;
    start(16'h0002, 16'h0005, 16'h0000);
    wait_cyc(40);
    chk(16'h0003, hi_len);
    chk(16'h0003, lo_len);
    chk_reg(ADDR_FLAGS, 16'h0103, 16'h0103);
    // stop first: a match in the clearing cycle would set the flag again
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_FLAGS, 16'h0003);
    chk_reg(ADDR_FLAGS, 16'h0103, 16'h0000);
    start(16'h0001, 16'h0005, 16'h0010);
    wait_cyc(40);
    chk(16'h0004, hi_len);
    chk(16'h0002, lo_len);
    $display("test data waveform done");
  endtask

  task automatic t_carrier;
    wr(ADDR_CARRIER, 16'h0100);
    wr(ADDR_CAR_CTRL, 16'h0001);
    start(16'h0009, 16'h0013, 16'h0000);
    wait_cyc(60);
    chk(16'h0001, hi_len);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_CARRIER, 16'h0402);
    start(16'h0009, 16'h0013, 16'h0000);
    wait_cyc(60);
    chk(16'h0003, hi_len);
    wr(ADDR_CAR_CTRL, 16'h0000);
    $display("test carrier done");
  endtask

  task automatic t_oneshot;
    start(16'h0002, 16'h0005, 16'h0004);
    wait_cyc(20);
    chk_reg(ADDR_FLAGS, 16'h0100, 16'h0000);
    chk_reg(ADDR_COUNT, 16'hffff, 16'h0000);
    chk(16'h0000, {15'h0, ir_tx_out});
    $display("test one-shot done");
  endtask

  task automatic t_shadow;
    start(16'h0014, 16'h0028, 16'h0008);
    wait_cyc(50);
    wr(ADDR_DUTY, 16'h0000);
    chk_reg(ADDR_FLAGS, 16'h0200, 16'h0200);
    chk(16'h0015, hi_len);
    wait_cyc(100);
    chk_reg(ADDR_FLAGS, 16'h0600, 16'h0000);
    chk(16'h0001, hi_len);
    wr(ADDR_CTRL, 16'h0101);
    wr(ADDR_DUTY, 16'h0004);
    chk_reg(ADDR_FLAGS, 16'h0200, 16'h0000);
    wait_cyc(100);
    chk(16'h0005, hi_len);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_CTRL, 16'h0000);
    $display("test shadow done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the whole sequence needs about 600 cycles; allow twenty-five times that
  initial
  begin
    #(25 * 15000);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_cyc(2);
    t_reset();
    t_data();
    t_carrier();
    t_oneshot();
    t_shadow();
    test_done();
  end
endmodule // ir_tx_unit_tb
